// ---- core/nedc_status.sv ----
// Functional notes
// RULE_01 - 32-bit read/write transfer buffer feeds words to the codec; resets zero.
// RULE_02 - 32-bit read-only corrected buffer holds words sent to third page RAM.
// RULE_03 - busy bit 2 shows the Chien search stage running.
// RULE_04 - busy bit 1 shows the sigma calculation stage running.
// RULE_05 - busy bit 0 shows syndrome running; bits 31 to 3 read zero.
// RULE_06 - error flags: sector 1 at bit 0 to sector 8 at bit 7, 1 means clean.
// RULE_07 - eight decode state registers; auto mode keeps them on clean sectors.
// RULE_08 - outcome bits 9:8: 00 clean, 01 correctable, 1x uncorrectable.
// RULE_09 - bit 7 flags CRC error after fix; only in BCH4 with auto correction.
// RULE_10 - bit 6 flags Chien search found sector uncorrectable.
// RULE_11 - bit 5 flags sigma calculation found sector uncorrectable.
// RULE_12 - bit 4 flags all-zero syndromes with a CRC error.
// RULE_13 - count bits 3:0: 0 none, 1 to 8 errors, 15 uncorrectable.
// RULE_14 - four position words per sector, 13-bit fields at 12:0 and 28:16.
// RULE_15 - positions 5 to 8 are invalid when BCH4 mode is selected.
// RULE_16 - software sets direction 0 to encode and 1 to decode.
// RULE_17 - software sets strength 0 for BCH4 with CRC, 1 for BCH8.
// RULE_18 - software sets correction mode 0 software, 1 automatic.
// RULE_19 - flags, state and positions of a sector update together at its end; in auto mode a clean sector updates only its flag.
`timescale 1ns/100ps
`default_nettype none

module nedc_status
   import nedc_pkg::*;
#(
   parameter int NUM_SECTORS = NEDC_SECTORS,
   parameter int POS_PER_SECTOR = NEDC_POS_PER_SECTOR,
   parameter int POS_W = NEDC_POS_W
)
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // register port
   input wire logic [NEDC_AW-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // mode to the codec
   output logic decode_dir_o,
   output logic bch8_sel_o,
   output logic auto_fix_o,
   // word path into the codec
   output logic codec_word_valid_o,
   output logic [31:0] codec_word_in_o,
   // decoder core status
   input wire nedc_busy_t busy_i,
   input wire nedc_result_t result_i,
   // corrected words toward the third page RAM
   input wire nedc_word_t corr_word_i,
   output logic third_page_ram_we_o,
   output logic [31:0] third_page_ram_data_o,
   // interrupt
   output logic irq_o
);

   // software-visible state
   logic [31:0] xfer_buf_ff;
   logic xfer_valid_ff;
   logic [31:0] corr_buf_ff;
   logic ram_we_ff;
   logic [BUSY_W-1:0] busy_ff;
   logic [CTRL_W-1:0] ctrl_ff;
   logic [IRQ_W-1:0] int_stat_ff;
   logic [IRQ_W-1:0] int_mask_ff;
   logic [31:0] rdata_ff;

   // per-sector result storage
   logic [NUM_SECTORS-1:0] clean_ff;
   logic [DS_W-1:0] ds_ff [NUM_SECTORS];
   logic [POS_W-1:0] pos_ff [NUM_SECTORS][POS_PER_SECTOR];

   // next values
   logic [CTRL_W-1:0] nxt_ctrl;
   logic [31:0] nxt_xfer_buf;
   logic [31:0] nxt_corr_buf;
   logic [BUSY_W-1:0] nxt_busy;
   logic [IRQ_W-1:0] nxt_int_mask;
   logic [DS_W-1:0] nxt_ds;
   logic [31:0] nxt_rdata;

   // decoded strobes and events
   logic wr_xfer;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic res_clean;
   logic ds_update;
   logic [NUM_SECTORS-1:0] sector_hit;
   logic [NUM_SECTORS-1:0] commit_flag;
   logic [NUM_SECTORS-1:0] commit_state;
   logic [IRQ_W-1:0] events;

   // result fields taken at the done pulse
   logic [OUTCOME_W-1:0] res_outcome;
   logic [COUNT_W-1:0] res_count;
   logic res_uncorr;
   logic crc_fix_meaningful;

   assign wr_xfer = reg_wr_i && (reg_addr_i == ADDR_XFER_BUF);
   assign wr_ctrl = reg_wr_i && (reg_addr_i == ADDR_CTRL);
   assign wr_stat = reg_wr_i && (reg_addr_i == ADDR_INT_STAT);
   assign wr_mask = reg_wr_i && (reg_addr_i == ADDR_INT_MASK);

   assign res_outcome = result_i.outcome;
   assign res_count = result_i.error_count;
   assign res_uncorr = res_outcome[OUTCOME_MSB];
   // crc-after-fix has no meaning outside BCH4 with auto correction
   assign crc_fix_meaningful = !ctrl_ff[CTRL_SEL8_BIT] &&
      ctrl_ff[CTRL_AUTO_BIT]; // RULE_09

   // software-held mode bits steer the result capture
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl) begin
         nxt_ctrl = reg_wdata_i[CTRL_W-1:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         ctrl_ff <= CTRL_RESET;
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   assign decode_dir_o = ctrl_ff[CTRL_DIR_BIT]; // RULE_16
   assign bch8_sel_o = ctrl_ff[CTRL_SEL8_BIT]; // RULE_17
   assign auto_fix_o = ctrl_ff[CTRL_AUTO_BIT]; // RULE_18

   // transfer buffer: each write hands one word to the codec
   always_comb begin
      nxt_xfer_buf = xfer_buf_ff;
      if (wr_xfer) begin
         nxt_xfer_buf = reg_wdata_i; // RULE_01
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         xfer_buf_ff <= WORD_RESET;
      end else begin
         xfer_buf_ff <= nxt_xfer_buf;
      end
   end

   // one-cycle strobe tells the codec a fresh word is waiting
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         xfer_valid_ff <= 1'b0;
      end else begin
         xfer_valid_ff <= wr_xfer; // RULE_01
      end
   end

   assign codec_word_valid_o = xfer_valid_ff;
   assign codec_word_in_o = xfer_buf_ff;

   // corrected words are kept for software and forwarded to the page RAM
   always_comb begin
      nxt_corr_buf = corr_buf_ff;
      if (corr_word_i.valid) begin
         nxt_corr_buf = corr_word_i.data; // RULE_02
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         corr_buf_ff <= WORD_RESET;
      end else begin
         corr_buf_ff <= nxt_corr_buf;
      end
   end

   // page ram write lags the word by one cycle, data held until the next
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         ram_we_ff <= 1'b0;
      end else begin
         ram_we_ff <= corr_word_i.valid;
      end
   end

   assign third_page_ram_we_o = ram_we_ff;
   assign third_page_ram_data_o = corr_buf_ff;

   // stage busy levels sampled once so a read sees one coherent set
   always_comb begin
      nxt_busy = '0;
      nxt_busy[BUSY_CHIEN_BIT] = busy_i.chien; // RULE_03
      nxt_busy[BUSY_SIGMA_BIT] = busy_i.sigma; // RULE_04
      nxt_busy[BUSY_SYN_BIT] = busy_i.syndrome; // RULE_05
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         busy_ff <= '0;
      end else begin
         busy_ff <= nxt_busy;
      end
   end

   assign res_clean = (res_outcome == OUTCOME_NONE);
   // a clean sector leaves its state alone under automatic correction
   assign ds_update = result_i.done &&
      !(ctrl_ff[CTRL_AUTO_BIT] && res_clean); // RULE_07

   always_comb begin
      nxt_ds = DS_RESET;
      nxt_ds[DS_OUTCOME_LSB +: OUTCOME_W] = res_outcome; // RULE_08
      nxt_ds[DS_CRC_FIX_BIT] = result_i.crc_fail_after_fix &&
         crc_fix_meaningful; // RULE_09
      nxt_ds[DS_SEARCH_BIT] = result_i.search_uncorrectable; // RULE_10
      nxt_ds[DS_SIGMA_BIT] = result_i.sigma_uncorrectable; // RULE_11
      nxt_ds[DS_ZSYN_BIT] = result_i.zero_syndrome_crc_fail; // RULE_12
      nxt_ds[DS_COUNT_LSB +: COUNT_W] = res_count; // RULE_13
   end

   // per-sector results commit on the done pulse; state and positions skip a clean sector under automatic correction
   for (genvar s = 0; s < NUM_SECTORS; s++) begin : g_sector
      assign sector_hit[s] = (result_i.sector == SEC_W'(s));
      assign commit_flag[s] = result_i.done && sector_hit[s];
      assign commit_state[s] = ds_update && sector_hit[s];

      // the clean flag follows every finished sector, whatever the mode
      always_ff @(posedge ref_clk_i) begin
         if (!nrst_i) begin
            clean_ff[s] <= 1'b0;
         end else if (commit_flag[s]) begin
            clean_ff[s] <= res_clean; // RULE_06 RULE_19
         end
      end

      always_ff @(posedge ref_clk_i) begin
         if (!nrst_i) begin
            ds_ff[s] <= DS_RESET;
         end else if (commit_state[s]) begin
            ds_ff[s] <= nxt_ds; // RULE_19
         end
      end

      for (genvar p = 0; p < POS_PER_SECTOR; p++) begin : g_pos
         always_ff @(posedge ref_clk_i) begin
            if (!nrst_i) begin
               pos_ff[s][p] <= '0;
            end else if (commit_state[s]) begin
               pos_ff[s][p] <= result_i.pos[p]; // RULE_14 RULE_19
            end
         end
      end
   end

   // interrupt events: sector finished, sector uncorrectable, corrected word
   always_comb begin
      events = IRQ_RESET;
      events[IRQ_DONE_BIT] = result_i.done;
      events[IRQ_UNCORR_BIT] = result_i.done && res_uncorr;
      events[IRQ_CORR_WORD_BIT] = corr_word_i.valid;
   end

   // set beats write-one-to-clear so no event is dropped
   for (genvar b = 0; b < IRQ_W; b++) begin : g_irq
      logic clr;
      assign clr = wr_stat && reg_wdata_i[b];

      always_ff @(posedge ref_clk_i) begin
         if (!nrst_i) begin
            int_stat_ff[b] <= IRQ_RESET[b];
         end else if (events[b]) begin
            int_stat_ff[b] <= 1'b1;
         end else if (clr) begin
            int_stat_ff[b] <= 1'b0;
         end
      end
   end

   always_comb begin
      nxt_int_mask = int_mask_ff;
      if (wr_mask) begin
         nxt_int_mask = reg_wdata_i[IRQ_W-1:0];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         int_mask_ff <= IRQ_RESET;
      end else begin
         int_mask_ff <= nxt_int_mask;
      end
   end

   assign irq_o = |(int_stat_ff & int_mask_ff);

   // read decode, answer registered one cycle after the strobe
   logic pos_hit;
   logic ds_hit;
   logic [SEC_W-1:0] pos_sec;
   logic [WIDX_W-1:0] pos_widx;
   logic [SEC_W-1:0] pos_lo_idx;
   logic [SEC_W-1:0] pos_hi_idx;
   logic pos_hidden;
   logic [SEC_W-1:0] ds_sec;
   logic [31:0] pos_word;
   logic [31:0] ds_word;
   logic [31:0] csr_word;

   assign pos_hit = (reg_addr_i & ADDR_POS_MASK) == ADDR_POS_BASE;
   assign ds_hit = (reg_addr_i & ADDR_DS_MASK) == ADDR_DS_BASE;
   assign pos_sec = reg_addr_i[POS_SEC_LSB +: SEC_W];
   assign pos_widx = reg_addr_i[POS_WORD_LSB +: WIDX_W];
   assign pos_lo_idx = {pos_widx, 1'b0};
   assign pos_hi_idx = {pos_widx, 1'b1};
   assign ds_sec = reg_addr_i[DS_SEC_LSB +: SEC_W];
   // upper four positions carry nothing in BCH4 mode
   assign pos_hidden = !ctrl_ff[CTRL_SEL8_BIT] &&
      (32'(pos_lo_idx) >= POS_VALID_BCH4); // RULE_15

   // stored positions survive a mode change; only the read view is masked
   always_comb begin
      pos_word = WORD_RESET;
      if (!pos_hidden) begin
         pos_word[POS_LO_LSB +: POS_W] =
            pos_ff[pos_sec][pos_lo_idx]; // RULE_14
         pos_word[POS_HI_LSB +: POS_W] =
            pos_ff[pos_sec][pos_hi_idx]; // RULE_14
      end
   end

   always_comb begin
      ds_word = WORD_RESET;
      ds_word[DS_W-1:0] = ds_ff[ds_sec]; // RULE_07
   end

   always_comb begin
      csr_word = WORD_RESET;
      unique case (reg_addr_i)
         ADDR_XFER_BUF: csr_word = xfer_buf_ff; // RULE_01
         ADDR_CORR_BUF: csr_word = corr_buf_ff; // RULE_02
         ADDR_BUSY: csr_word[BUSY_W-1:0] = busy_ff; // RULE_05
         ADDR_ERR_FLAGS: csr_word[NUM_SECTORS-1:0] = clean_ff; // RULE_06
         ADDR_CTRL: csr_word[CTRL_W-1:0] = ctrl_ff;
         ADDR_INT_STAT: csr_word[IRQ_W-1:0] = int_stat_ff;
         ADDR_INT_MASK: csr_word[IRQ_W-1:0] = int_mask_ff;
         default: csr_word = WORD_RESET;
      endcase
   end

   // the position window wins over the state window, then the csrs
   always_comb begin
      if (pos_hit) begin
         nxt_rdata = pos_word;
      end else if (ds_hit) begin
         nxt_rdata = ds_word;
      end else begin
         nxt_rdata = csr_word;
      end
   end

   // data stand only in the cycle after the read strobe
   always_ff @(posedge ref_clk_i) begin
      if (!nrst_i) begin
         rdata_ff <= WORD_RESET;
      end else if (reg_rd_i) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= WORD_RESET;
      end
   end

   assign reg_rdata_o = rdata_ff;

endmodule // nedc_status

`default_nettype wire

// ---- core/nedc_pkg.sv ----
package nedc_pkg;

   localparam int NEDC_SECTORS = 8;
   localparam int NEDC_POS_PER_SECTOR = 8;
   localparam int NEDC_POS_W = 13;
   localparam int NEDC_AW = 8;

   // register byte addresses
   localparam logic [7:0] ADDR_XFER_BUF = 8'h00;
   localparam logic [7:0] ADDR_CORR_BUF = 8'h04;
   localparam logic [7:0] ADDR_BUSY = 8'h08;
   localparam logic [7:0] ADDR_ERR_FLAGS = 8'h0c;
   localparam logic [7:0] ADDR_CTRL = 8'h10;
   localparam logic [7:0] ADDR_INT_STAT = 8'h14;
   localparam logic [7:0] ADDR_INT_MASK = 8'h18;
   localparam logic [7:0] ADDR_DS_BASE = 8'h40;
   localparam logic [7:0] ADDR_DS_MASK = 8'he0;
   localparam logic [7:0] ADDR_POS_BASE = 8'h80;
   localparam logic [7:0] ADDR_POS_MASK = 8'h80;

   // control register fields
   localparam int CTRL_DIR_BIT = 0;
   localparam int CTRL_SEL8_BIT = 1;
   localparam int CTRL_AUTO_BIT = 2;
   localparam int CTRL_W = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

   // busy register fields
   localparam int BUSY_SYN_BIT = 0;
   localparam int BUSY_SIGMA_BIT = 1;
   localparam int BUSY_CHIEN_BIT = 2;
   localparam int BUSY_W = 3;

   // decode state fields
   localparam int DS_W = 10;
   localparam int DS_OUTCOME_LSB = 8;
   localparam int DS_CRC_FIX_BIT = 7;
   localparam int DS_SEARCH_BIT = 6;
   localparam int DS_SIGMA_BIT = 5;
   localparam int DS_ZSYN_BIT = 4;
   localparam int DS_COUNT_LSB = 0;
   localparam logic [DS_W-1:0] DS_RESET = 10'h000;

   localparam logic [1:0] OUTCOME_NONE = 2'h0;
   localparam logic [1:0] OUTCOME_FIXABLE = 2'h1;
   localparam logic [1:0] OUTCOME_UNCORR = 2'h2;
   localparam logic [3:0] COUNT_NONE = 4'h0;
   localparam logic [3:0] COUNT_MAX = 4'h8;
   localparam logic [3:0] COUNT_UNCORR = 4'hf;

   // position word layout
   localparam int POS_LO_LSB = 0;
   localparam int POS_HI_LSB = 16;
   localparam int POS_VALID_BCH4 = 4;

   // address and field widths of the per-sector windows
   localparam int POS_SEC_LSB = 4;
   localparam int POS_WORD_LSB = 2;
   localparam int DS_SEC_LSB = 2;
   localparam int SEC_W = 3;
   localparam int WIDX_W = 2;
   localparam int OUTCOME_W = 2;
   localparam int OUTCOME_MSB = 1;
   localparam int COUNT_W = 4;

   // interrupt events
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_UNCORR_BIT = 1;
   localparam int IRQ_CORR_WORD_BIT = 2;
   localparam int IRQ_W = 3;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   typedef struct packed {
      logic chien;
      logic sigma;
      logic syndrome;
   } nedc_busy_t;

   typedef struct packed {
      logic done;
      logic [2:0] sector;
      logic [1:0] outcome;
      logic crc_fail_after_fix;
      logic search_uncorrectable;
      logic sigma_uncorrectable;
      logic zero_syndrome_crc_fail;
      logic [3:0] error_count;
      logic [NEDC_POS_PER_SECTOR-1:0][NEDC_POS_W-1:0] pos;
   } nedc_result_t;

   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } nedc_word_t;

endpackage

// ---- tb/nedc_status_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module nedc_status_asserts
   import nedc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // register port
   input wire logic [NEDC_AW-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   // codec side
   input wire logic decode_dir_o,
   input wire logic bch8_sel_o,
   input wire logic auto_fix_o,
   input wire logic codec_word_valid_o,
   input wire logic [31:0] codec_word_in_o,
   input wire nedc_busy_t busy_i,
   input wire nedc_result_t result_i,
   input wire nedc_word_t corr_word_i,
   input wire logic third_page_ram_we_o,
   input wire logic [31:0] third_page_ram_data_o,
   input wire logic irq_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   a_word_pulse: assert property (reg_wr_i && reg_addr_i == ADDR_XFER_BUF |=>
      codec_word_valid_o && codec_word_in_o == $past(reg_wdata_i))
      else $error("transfer word not forwarded");
   a_word_cause: assert property (codec_word_valid_o |-> $past(reg_wr_i) &&
      $past(reg_addr_i) == ADDR_XFER_BUF) else $error("stray codec word");
   a_ram_pulse: assert property (corr_word_i.valid |=> third_page_ram_we_o &&
      third_page_ram_data_o == $past(corr_word_i.data))
      else $error("corrected word not passed on");
   a_ram_cause: assert property (third_page_ram_we_o |-> $past(corr_word_i.valid))
      else $error("stray page ram write");
   a_ram_hold: assert property (!corr_word_i.valid |=> $stable(third_page_ram_data_o))
      else $error("corrected buffer changed unprompted");
   a_busy_read: assert property (reg_rd_i && reg_addr_i == ADDR_BUSY && $past(nrst_i)
      |=> reg_rdata_o == {29'h0, $past(busy_i, 2)}) else $error("busy readback wrong");
   a_ctrl_out: assert property (reg_wr_i && reg_addr_i == ADDR_CTRL |=>
      {auto_fix_o, bch8_sel_o, decode_dir_o} == $past(reg_wdata_i[2:0]))
      else $error("mode outputs not written");
   a_mode_hold: assert property (!(reg_wr_i && reg_addr_i == ADDR_CTRL) |=>
      $stable({auto_fix_o, bch8_sel_o, decode_dir_o})) else $error("mode changed");
   a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
      else $error("read data outside its cycle");
   c_uncorr: cover property (result_i.done && result_i.outcome == OUTCOME_UNCORR);
   c_irq: cover property (irq_o);
   c_ram: cover property (third_page_ram_we_o);
endmodule // nedc_status_asserts
bind nedc_status nedc_status_asserts nedc_status_asserts_inst (.ref_clk_i, .nrst_i,
   .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .decode_dir_o,
   .bch8_sel_o, .auto_fix_o, .codec_word_valid_o, .codec_word_in_o, .busy_i,
   .result_i, .corr_word_i, .third_page_ram_we_o, .third_page_ram_data_o, .irq_o);
`default_nettype wire

// ---- tb/nedc_status_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module nedc_status_tb_top;
   import nedc_pkg::*;
   logic ref_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [31:0] reg_rdata_o, codec_word_in_o, third_page_ram_data_o;
   logic decode_dir_o, bch8_sel_o, auto_fix_o, codec_word_valid_o;
   logic third_page_ram_we_o, irq_o;
   nedc_busy_t busy_i = '0;
   nedc_result_t result_i = '0;
   nedc_word_t corr_word_i = '0;
   int num_errors = 0;
   int total_checks = 0;
   logic [7:0] rst_a [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
      8'h80, 8'h9c, 8'h20};
   always #50 ref_clk_i = ~ref_clk_i;
   nedc_status nedc_status_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .decode_dir_o(decode_dir_o),
      .bch8_sel_o(bch8_sel_o), .auto_fix_o(auto_fix_o),
      .codec_word_valid_o(codec_word_valid_o), .codec_word_in_o(codec_word_in_o),
      .busy_i(busy_i), .result_i(result_i), .corr_word_i(corr_word_i),
      .third_page_ram_we_o(third_page_ram_we_o),
      .third_page_ram_data_o(third_page_ram_data_o), .irq_o(irq_o));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 chk(reg_rdata_o, exp);
   endtask
   task automatic post(input logic [2:0] s, input logic [1:0] oc,
      input logic [3:0] fl, input logic [3:0] cnt, input logic [12:0] p0);
      nedc_result_t r;
      r = '0;
      r.done = 1'b1;
      r.sector = s;
      r.outcome = oc;
      {r.crc_fail_after_fix, r.search_uncorrectable, r.sigma_uncorrectable,
         r.zero_syndrome_crc_fail} = fl;
      r.error_count = cnt;
      for (int i = 0; i < 8; i++) r.pos[i] = p0 + 13'(i);
      @(posedge ref_clk_i);
      result_i <= r;
      @(posedge ref_clk_i);
      result_i <= '0;
   endtask
   // positions 5 to 8 hidden in the four-bit mode
   task automatic pos_chk(input logic [7:0] b, input logic [12:0] p0, input bit h4);
      for (int w = 0; w < 4; w++)
         rd(b + 8'(4 * w), (h4 && w >= 2) ? 32'h0 : {3'h0, p0 + 13'(2 * w + 1),
            3'h0, p0 + 13'(2 * w)});
   endtask
   task automatic finish_test();
      $display("checks=%0d errors=%0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge ref_clk_i);
      num_errors++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      foreach (rst_a[i]) rd(rst_a[i], 32'h0);
      for (int i = 0; i < 8; i++) rd(8'h40 + 8'(4 * i), 32'h0);
      wr(ADDR_INT_MASK, 32'h3);
      wr(ADDR_XFER_BUF, 32'hdead_0001);
      #1 chk({31'h0, codec_word_valid_o}, 32'h1);
      chk(codec_word_in_o, 32'hdead_0001);
      rd(ADDR_XFER_BUF, 32'hdead_0001);
      @(posedge ref_clk_i);
      corr_word_i <= '{1'b1, 32'h1357_9bdf};
      @(posedge ref_clk_i);
      corr_word_i <= '0;
      #1 chk({31'h0, third_page_ram_we_o}, 32'h1);
      wr(ADDR_CORR_BUF, 32'h0);
      rd(ADDR_CORR_BUF, 32'h1357_9bdf);
      for (int n = 0; n < 3; n++) begin
         @(posedge ref_clk_i);
         busy_i <= nedc_busy_t'(3'h1 << n);
         repeat (2) @(posedge ref_clk_i);
         rd(ADDR_BUSY, 32'h1 << n);
      end
      busy_i <= '0;
      wr(ADDR_CTRL, 32'h3);
      post(3'h2, 2'h1, 4'h0, 4'h3, 13'h1000);
      rd(ADDR_ERR_FLAGS, 32'h0);
      rd(8'h48, 32'h103);
      pos_chk(8'ha0, 13'h1000, 1'b0);
      chk({31'h0, irq_o}, 32'h1);
      rd(ADDR_INT_STAT, 32'h5);
      wr(ADDR_INT_STAT, 32'h5);
      #1 chk({31'h0, irq_o}, 32'h0);
      post(3'h7, 2'h2, 4'h6, 4'hf, 13'h0);
      rd(8'h5c, 32'h26f);
      rd(ADDR_INT_STAT, 32'h3);
      post(3'h0, 2'h0, 4'h0, 4'h0, 13'h5);
      rd(ADDR_ERR_FLAGS, 32'h01);
      wr(ADDR_CTRL, 32'h7);
      post(3'h2, 2'h0, 4'h0, 4'h0, 13'h0);
      rd(ADDR_ERR_FLAGS, 32'h05);
      rd(8'h48, 32'h103);
      pos_chk(8'ha0, 13'h1000, 1'b0);
      wr(ADDR_CTRL, 32'h5);
      post(3'h3, 2'h1, 4'h9, 4'h2, 13'h0a0);
      rd(8'h4c, 32'h192);
      pos_chk(8'hb0, 13'h0a0, 1'b1);
      wr(ADDR_CTRL, 32'h3);
      pos_chk(8'hb0, 13'h0a0, 1'b0);
      post(3'h4, 2'h1, 4'h8, 4'h8, 13'h1);
      rd(8'h50, 32'h108);
      finish_test();
   end
endmodule // nedc_status_tb_top
`default_nettype wire
